// >>> core/enh_capture.sv
// Enhancement register capture over the parallel or serial write port
`timescale 1ns/1ps
module enh_capture
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_smode,
  input wire logic i_enh_wr,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic [7:0] i_par_data,
  output logic [7:0] o_enh_value,
  output logic o_enh_written
);
  typedef struct packed
  {
    logic wr_prev;
    logic sclk_prev;
    logic [7:0] value;
    logic written;
  } cap_t;

  cap_t cap_r;
  cap_t cap_nxt;

  always_comb
  begin
    cap_nxt = cap_r;
    cap_nxt.written = 1'b0;
    cap_nxt.wr_prev = i_enh_wr;
    cap_nxt.sclk_prev = i_sclk;
    if (!i_smode && i_enh_wr && !cap_r.wr_prev)
    begin
      cap_nxt.value = i_par_data;
      cap_nxt.written = 1'b1;
    end
    else if (i_smode && i_enh_wr && i_sclk && !cap_r.sclk_prev)
    begin
      cap_nxt.value = {cap_r.value[6:0], i_sdata};
      cap_nxt.written = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cap_r <= '{wr_prev: 1'b0, sclk_prev: 1'b0, value: pd_pkg::ENH_RST, written: 1'b0};
    end
    else
    begin
      cap_r <= cap_nxt;
    end
  end

  assign o_enh_value = cap_r.value;
  assign o_enh_written = cap_r.written;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_par_latch: assert property (!i_smode && i_enh_wr && !cap_r.wr_prev |=> o_enh_value == $past(i_par_data))
    else $error("Parallel write not latched");
  a_ser_shift: assert property (i_smode && i_enh_wr && i_sclk && !cap_r.sclk_prev
    |=> o_enh_value == {$past(o_enh_value[6:0]), $past(i_sdata)})
    else $error("Serial bit not shifted in");
  a_ser_hold: assert property (i_smode && !i_enh_wr |=> $stable(o_enh_value))
    else $error("Serial shift without write strobe");
endmodule

// >>> core/pd_lock_top.sv
// Phase comparator, lock monitor, monitor pins and APB registers
`timescale 1ns/1ps
module pd_lock_top
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_main_div,
  input wire logic i_ref_div,
  input wire logic i_modulus_select,
  input wire logic i_prescaler_raw,
  input wire logic i_enh_n,
  input wire logic i_smode,
  input wire logic i_enh_wr,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic [7:0] i_par_data,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_pump_down_pulse_n,
  output logic o_pump_up_pulse_n,
  output logic o_pulse_combined,
  output logic o_lock_indicator_o,
  output logic o_lock_indicator_oe,
  output logic o_main_div_monitor,
  output logic o_ref_div_monitor,
  output logic o_dout,
  output logic o_irq
);
  typedef struct packed
  {
    logic main_prev;
    logic ref_prev;
    logic pump_up_n;
    logic pump_dn_n;
    logic comb;
    logic [7:0] lock_cnt;
    logic locked;
    logic ld_o;
    logic ld_oe;
    logic main_mon;
    logic ref_mon;
    logic dout;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic pfd_en;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic irq;
  } state_t;

  localparam state_t STATE_RST = '{
    main_prev: 1'b0,
    ref_prev: 1'b0,
    pump_up_n: 1'b1,
    pump_dn_n: 1'b1,
    comb: 1'b0,
    lock_cnt: 8'h00,
    locked: 1'b0,
    ld_o: 1'b0,
    ld_oe: 1'b1,
    main_mon: 1'b0,
    ref_mon: 1'b0,
    dout: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000,
    pfd_en: pd_pkg::CTRL_RST[pd_pkg::CTRL_PFD_EN],
    int_stat: 3'h0,
    int_mask: pd_pkg::INT_MASK_RST,
    irq: 1'b0
  };

  state_t st_r;
  state_t st_nxt;
  logic [7:0] enh_value;
  logic enh_written;

  enh_capture u_enh_capture
  (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_smode(i_smode),
    .i_enh_wr(i_enh_wr),
    .i_sclk(i_sclk),
    .i_sdata(i_sdata),
    .i_par_data(i_par_data),
    .o_enh_value(enh_value),
    .o_enh_written(enh_written)
  );

  always_comb
  begin
    logic main_rise;
    logic ref_rise;
    logic up_act;
    logic dn_act;
    logic enh_act;
    logic acc;
    logic wr_acc;
    logic hit;
    logic [31:0] rd;
    logic [2:0] ev;
    logic [2:0] clr;
    main_rise = 1'b0;
    ref_rise = 1'b0;
    up_act = 1'b0;
    dn_act = 1'b0;
    enh_act = 1'b0;
    acc = 1'b0;
    wr_acc = 1'b0;
    hit = 1'b0;
    rd = 32'h0000_0000;
    ev = 3'h0;
    clr = 3'h0;
    st_nxt = st_r;

    // Pins are sampled as plain levels; pulled-down pins arrive as zero
    st_nxt.main_prev = i_main_div;
    st_nxt.ref_prev = i_ref_div;
    main_rise = i_main_div && !st_r.main_prev;
    ref_rise = i_ref_div && !st_r.ref_prev;

    // Phase-frequency comparator
    up_act = !st_r.pump_up_n;
    dn_act = !st_r.pump_dn_n;
    if (!st_r.pfd_en)
    begin
      up_act = 1'b0;
      dn_act = 1'b0;
    end
    else
    begin
      up_act = up_act || ref_rise;
      dn_act = dn_act || main_rise;
      if (up_act && dn_act)
      begin
        up_act = 1'b0;
        dn_act = 1'b0;
      end
    end
    st_nxt.pump_up_n = !up_act;
    st_nxt.pump_dn_n = !dn_act;
    st_nxt.comb = !(st_nxt.pump_up_n && st_nxt.pump_dn_n);

    // Lock filter on the combined pulse signal
    if (st_r.comb)
    begin
      st_nxt.lock_cnt = 8'h00;
    end
    else if (st_r.lock_cnt != pd_pkg::LOCK_CNT_MAX)
    begin
      st_nxt.lock_cnt = st_r.lock_cnt + 8'h01;
    end
    st_nxt.locked = !st_r.comb && (st_nxt.lock_cnt == pd_pkg::LOCK_CNT_MAX);
    st_nxt.ld_o = 1'b0;
    st_nxt.ld_oe = !st_nxt.locked;

    // Monitor pins and data output
    enh_act = !i_enh_n;
    st_nxt.main_mon = i_main_div;
    st_nxt.ref_mon = i_ref_div;
    st_nxt.dout = 1'b0;
    if (enh_act)
    begin
      if (enh_value[pd_pkg::ENH_MAIN_OFF])
      begin
        st_nxt.main_mon = 1'b0;
      end
      if (enh_value[pd_pkg::ENH_REF_OFF])
      begin
        st_nxt.ref_mon = 1'b0;
      end
      if (enh_value[pd_pkg::ENH_DOUT_EN])
      begin
        st_nxt.dout = enh_value[pd_pkg::ENH_DOUT_PRE] ? i_prescaler_raw : i_modulus_select;
      end
    end

    // APB slave with one wait state
    acc = i_psel && i_penable && st_r.pready;
    wr_acc = acc && i_pwrite;
    hit = (i_paddr == pd_pkg::ADDR_CTRL) || (i_paddr == pd_pkg::ADDR_STATUS)
      || (i_paddr == pd_pkg::ADDR_INT_STAT) || (i_paddr == pd_pkg::ADDR_INT_MASK);
    case (i_paddr)
      pd_pkg::ADDR_CTRL: rd = {31'h0000_0000, st_r.pfd_en};
      pd_pkg::ADDR_STATUS: rd = {16'h0000, enh_value, 4'h0, enh_act, dn_act, up_act, st_r.locked};
      pd_pkg::ADDR_INT_STAT: rd = {29'h0000_0000, st_r.int_stat};
      pd_pkg::ADDR_INT_MASK: rd = {29'h0000_0000, st_r.int_mask};
      default: rd = 32'h0000_0000;
    endcase
    if (i_psel && i_penable && !st_r.pready)
    begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = i_pwrite ? 32'h0000_0000 : rd;
      st_nxt.pslverr = !hit;
    end
    else
    begin
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
    end
    if (wr_acc && i_paddr == pd_pkg::ADDR_CTRL)
    begin
      st_nxt.pfd_en = i_pwdata[pd_pkg::CTRL_PFD_EN];
    end
    if (wr_acc && i_paddr == pd_pkg::ADDR_INT_MASK)
    begin
      st_nxt.int_mask = i_pwdata[2:0];
    end
    if (wr_acc && i_paddr == pd_pkg::ADDR_INT_STAT)
    begin
      clr = i_pwdata[2:0];
    end

    // Sticky events, set beats clear
    ev[pd_pkg::INT_LOCK_GAIN] = st_nxt.locked && !st_r.locked;
    ev[pd_pkg::INT_LOCK_LOSS] = !st_nxt.locked && st_r.locked;
    ev[pd_pkg::INT_ENH_WR] = enh_written;
    st_nxt.int_stat = (st_r.int_stat & ~clr) | ev;
    st_nxt.irq = |(st_nxt.int_stat & st_nxt.int_mask);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_r <= STATE_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_prdata = st_r.prdata;
  assign o_pready = st_r.pready;
  assign o_pslverr = st_r.pslverr;
  assign o_pump_down_pulse_n = st_r.pump_dn_n;
  assign o_pump_up_pulse_n = st_r.pump_up_n;
  assign o_pulse_combined = st_r.comb;
  assign o_lock_indicator_o = st_r.ld_o;
  assign o_lock_indicator_oe = st_r.ld_oe;
  assign o_main_div_monitor = st_r.main_mon;
  assign o_ref_div_monitor = st_r.ref_mon;
  assign o_dout = st_r.dout;
  assign o_irq = st_r.irq;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_dn_on_lead: assert property (st_r.pfd_en && i_main_div && !st_r.main_prev
    && !(i_ref_div && !st_r.ref_prev) && o_pump_up_pulse_n |=> !o_pump_down_pulse_n && o_pump_up_pulse_n)
    else $error("Down pulse missing on main lead");

  a_up_on_lead: assert property (st_r.pfd_en && i_ref_div && !st_r.ref_prev
    && !(i_main_div && !st_r.main_prev) && o_pump_down_pulse_n |=> !o_pump_up_pulse_n && o_pump_down_pulse_n)
    else $error("Up pulse missing on reference lead");

  a_comb_nand: assert property (o_pulse_combined == !(o_pump_up_pulse_n && o_pump_down_pulse_n))
    else $error("Combined output is not the NAND");

  a_lock_drop: assert property ($rose(o_pulse_combined) |=> o_lock_indicator_oe)
    else $error("Lock pin not driven low after pulse");

  a_lock_pin: assert property (!o_lock_indicator_o && (o_lock_indicator_oe == !st_r.locked))
    else $error("Lock pin drive does not match lock state");

  a_enh_ignored: assert property (i_enh_n |=> o_main_div_monitor == $past(i_main_div)
    && o_ref_div_monitor == $past(i_ref_div) && !o_dout)
    else $error("Enhancement bits acted while disabled");

  a_main_quiet: assert property (!i_enh_n && enh_value[pd_pkg::ENH_MAIN_OFF] |=> !o_main_div_monitor)
    else $error("Main monitor not silenced");

  a_ref_quiet: assert property (!i_enh_n && enh_value[pd_pkg::ENH_REF_OFF] |=> !o_ref_div_monitor)
    else $error("Reference monitor not silenced");

  a_dout_select: assert property (!i_enh_n && enh_value[pd_pkg::ENH_DOUT_EN]
    |=> o_dout == ($past(enh_value[pd_pkg::ENH_DOUT_PRE]) ? $past(i_prescaler_raw) : $past(i_modulus_select)))
    else $error("Data output source wrong");

  a_coincide_quiet: assert property (i_main_div && !st_r.main_prev && i_ref_div && !st_r.ref_prev
    && o_pump_up_pulse_n && o_pump_down_pulse_n |=> o_pump_up_pulse_n && o_pump_down_pulse_n)
    else $error("Pulse on coincident edges");

  a_lock_held: assert property (o_pulse_combined |-> ##1 !st_r.locked ##1 (st_r.lock_cnt <= 8'h01))
    else $error("Lock filter not restarted");

  a_dn_hold: assert property (st_r.pfd_en && !o_pump_down_pulse_n && !(i_ref_div && !st_r.ref_prev)
    |=> !o_pump_down_pulse_n)
    else $error("Down pulse ended early");

  a_dn_release: assert property (!o_pump_down_pulse_n && i_ref_div && !st_r.ref_prev
    |=> o_pump_down_pulse_n && o_pump_up_pulse_n)
    else $error("Down pulse not ended by reference edge");

  a_up_hold: assert property (st_r.pfd_en && !o_pump_up_pulse_n && !(i_main_div && !st_r.main_prev)
    |=> !o_pump_up_pulse_n)
    else $error("Up pulse ended early");

  a_up_release: assert property (!o_pump_up_pulse_n && i_main_div && !st_r.main_prev
    |=> o_pump_up_pulse_n && o_pump_down_pulse_n)
    else $error("Up pulse not ended by main edge");

  a_never_both: assert property (o_pump_up_pulse_n || o_pump_down_pulse_n)
    else $error("Both correction outputs active");

  a_pfd_off: assert property (!st_r.pfd_en |=> o_pump_up_pulse_n && o_pump_down_pulse_n)
    else $error("Correction pulse while comparator disabled");

  a_lock_filter: assert property ($fell(o_lock_indicator_oe) |-> st_r.lock_cnt == pd_pkg::LOCK_CNT_MAX)
    else $error("Lock pin released before filter expired");

  a_main_follow: assert property (!i_enh_n && !enh_value[pd_pkg::ENH_MAIN_OFF]
    |=> o_main_div_monitor == $past(i_main_div))
    else $error("Main monitor not following divider");

  a_ref_follow: assert property (!i_enh_n && !enh_value[pd_pkg::ENH_REF_OFF]
    |=> o_ref_div_monitor == $past(i_ref_div))
    else $error("Reference monitor not following divider");

  a_dout_off: assert property (!i_enh_n && !enh_value[pd_pkg::ENH_DOUT_EN] |=> !o_dout)
    else $error("Data output active while disabled");

  a_pready_pulse: assert property (o_pready |=> !o_pready)
    else $error("Ready held longer than one cycle");
endmodule

// >>> core/pd_pkg.sv
// Constants for the phase detector and lock monitor
package pd_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned LOCK_TIME_NS = 1000;
  localparam int unsigned LOCK_CYCLES = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] LOCK_CNT_MAX = LOCK_CYCLES[7:0];
  localparam logic [7:0] ENH_RST = 8'h00;
  localparam int unsigned ENH_MAIN_OFF = 0;
  localparam int unsigned ENH_REF_OFF = 1;
  localparam int unsigned ENH_DOUT_PRE = 2;
  localparam int unsigned ENH_DOUT_EN = 3;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
  localparam int unsigned CTRL_PFD_EN = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int unsigned INT_LOCK_GAIN = 0;
  localparam int unsigned INT_LOCK_LOSS = 1;
  localparam int unsigned INT_ENH_WR = 2;
  localparam int unsigned INT_W = 3;
  localparam logic [2:0] INT_MASK_RST = 3'h0;
endpackage

// >>> tb/pd_lock_top_tb.sv
// Self-checking bench for the phase detector and lock monitor
`timescale 1ns/1ps
module pd_lock_top_tb;
  logic i_clk = 0, i_rst_n = 0, i_main_div, i_ref_div = 0, i_modulus_select = 0, i_prescaler_raw = 0;
  logic i_enh_n = 1, i_smode = 0, i_enh_wr = 0, i_sclk = 0, i_sdata = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [7:0] i_par_data = 8'h00, i_paddr = 8'h00, enh = 8'h00;
  logic [7:0] tbl [5] = '{8'h01, 8'h02, 8'h08, 8'h0c, 8'h00};
  logic [31:0] i_pwdata = 32'h00000000, o_prdata, rd;
  logic o_pready, o_pslverr, o_pump_down_pulse_n, o_pump_up_pulse_n, o_pulse_combined, o_lock_indicator_o;
  logic o_lock_indicator_oe, o_main_div_monitor, o_ref_div_monitor, o_dout, o_irq, err, up, dn, pm, pr, ms, ps, en;
  logic lk_exp = 0;
  logic bypass = 1, main_man = 0, ref_man = 0, ref_run = 0, mon_chk = 1, pfd = 1, me, re;
  int fails = 0, num_checks = 0, rc = 0, lk = 0;
  always #12.5 i_clk = ~i_clk;
  pd_lock_top uut (.i_clk, .i_rst_n, .i_main_div, .i_ref_div, .i_modulus_select, .i_prescaler_raw, .i_enh_n, .i_smode,
    .i_enh_wr, .i_sclk, .i_sdata, .i_par_data, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .o_pump_down_pulse_n, .o_pump_up_pulse_n, .o_pulse_combined, .o_lock_indicator_o, .o_lock_indicator_oe,
    .o_main_div_monitor, .o_ref_div_monitor, .o_dout, .o_irq);
  vco_model vco (.i_clk, .i_pump_up_pulse_n(o_pump_up_pulse_n), .i_pump_down_pulse_n(o_pump_down_pulse_n),
    .i_bypass(bypass), .i_main_man(main_man), .o_main_div(i_main_div));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1;
    i_penable <= 0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1;
    do
      @(posedge i_clk);
    while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
    if (w && a == pd_pkg::ADDR_CTRL)
      pfd <= d[0];
  endtask

  task automatic pulse(input logic m, input logic r);
    main_man <= m;
    ref_man <= r;
    @(posedge i_clk);
    main_man <= 0;
    ref_man <= 0;
    repeat (6) @(posedge i_clk);
  endtask

  // Parallel mode strobes eight times, serial mode shifts MSB first
  task automatic enh_wr(input logic n, input logic s, input logic [7:0] v);
    mon_chk = 0;
    i_enh_n <= n;
    i_smode <= s;
    i_par_data <= v;
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge i_clk);
      i_sdata <= v[i];
      i_sclk <= 0;
      i_enh_wr <= s;
      @(posedge i_clk);
      i_sclk <= 1;
      i_enh_wr <= 1;
    end
    @(posedge i_clk);
    i_enh_wr <= 0;
    i_sclk <= 0;
    enh = v;
    repeat (3) @(posedge i_clk);
    mon_chk = 1;
  endtask

  // Cycle model of detector, monitors and data output
  always @(posedge i_clk)
  begin
    i_modulus_select <= 1'($urandom);
    i_prescaler_raw <= 1'($urandom);
    rc <= rc + 1;
    i_ref_div <= ref_run ? (rc % 16 < 2) : ref_man;
    if (i_rst_n)
    begin
      check(o_pump_up_pulse_n, !up);
      check(o_pump_down_pulse_n, !dn);
      check(o_pulse_combined, up | dn);
      check(o_lock_indicator_o, 0);
      check(o_lock_indicator_oe, !lk_exp);
      if (mon_chk)
      begin
        check(o_main_div_monitor, pm & !(en & enh[0]));
        check(o_ref_div_monitor, pr & !(en & enh[1]));
        check(o_dout, en & enh[3] & (enh[2] ? ps : ms));
      end
    end
    me = i_main_div & !pm;
    re = i_ref_div & !pr;
    {up, dn} = {i_rst_n & pfd & !me & (re ? !dn : up), i_rst_n & pfd & !re & (me ? !up : dn)};
    lk = (!i_rst_n || o_pulse_combined) ? 0 : ((lk < pd_pkg::LOCK_CYCLES) ? lk + 1 : lk);
    lk_exp = i_rst_n && !o_pulse_combined && (lk == pd_pkg::LOCK_CYCLES);
    {pm, pr, ms, ps, en} = {i_main_div, i_ref_div, i_modulus_select, i_prescaler_raw, !i_enh_n};
  end

  initial
  begin
    void'($urandom(32'h9eaf87aa));
    tbl[4] = 8'($urandom);
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1;
    @(posedge i_clk);
    apb(0, 8'h10, 32'h00000000);
    check({rd[31:1], err}, 32'h00000001);
    pulse(1, 1);
    pulse(1, 0);
    pulse(0, 1);
    pulse(0, 1);
    pulse(1, 0);
    apb(1, pd_pkg::ADDR_CTRL, 32'h00000000);
    pulse(1, 0);
    pulse(0, 1);
    apb(1, pd_pkg::ADDR_CTRL, 32'h00000001);
    bypass <= 0;
    ref_run <= 1;
    repeat (600) @(posedge i_clk);
    check(o_lock_indicator_oe, 0);
    apb(0, pd_pkg::ADDR_STATUS, 32'h00000000);
    check(rd[0], 1);
    enh_wr(1, 0, 8'h0f);
    repeat (30) @(posedge i_clk);
    apb(1, pd_pkg::ADDR_INT_STAT, 32'h00000007);
    apb(1, pd_pkg::ADDR_INT_MASK, 32'h00000004);
    repeat (2) @(posedge i_clk);
    check(o_irq, 0);
    foreach (tbl[k])
    begin
      enh_wr(0, k[0], tbl[k]);
      apb(0, pd_pkg::ADDR_STATUS, 32'h00000000);
      check(rd[15:8], tbl[k]);
      check(o_irq, 1);
      apb(1, pd_pkg::ADDR_INT_STAT, 32'h00000004);
      repeat (2) @(posedge i_clk);
      check(o_irq, 0);
      repeat (30) @(posedge i_clk);
    end
    bypass <= 1;
    repeat (40) @(posedge i_clk);
    check(o_lock_indicator_oe, 1);
    final_report;
  end

  initial
  begin
    repeat (20000) @(posedge i_clk);
    fails++;
    final_report;
  end
endmodule

// >>> tb/vco_model.sv
// Behavioural loop filter and VCO closing the loop onto the main divider
`timescale 1ns/1ps
module vco_model
(
  input wire logic i_clk,
  input wire logic i_pump_up_pulse_n,
  input wire logic i_pump_down_pulse_n,
  input wire logic i_bypass,
  input wire logic i_main_man,
  output logic o_main_div
);
  logic u = 0;
  logic d = 0;
  int cnt = 5;
  initial o_main_div = 1'b0;
  always @(posedge i_clk)
  begin
    u = u | (i_pump_up_pulse_n === 1'b0);
    d = d | (i_pump_down_pulse_n === 1'b0);
    cnt = cnt + 1;
    if (cnt >= 16 - u + d)
    begin
      cnt = 0;
      u = 0;
      d = 0;
    end
    o_main_div <= i_bypass ? i_main_man : (cnt < 2);
  end
endmodule
